/* rtl/psv_pkg.sv */
// shared constants, types and register map of the port supervisor
// assumes a 200 MHz system clock and a 32-bit AHB-Lite register bus
package psv_pkg;
  localparam int NPORT = 12;
  localparam int NQUAD = 3;
  localparam int CLK_PERIOD_NS = 5;
  // readback refresh and averaging
  localparam int REFRESH_MS = 100;
  localparam int SAMPLES_PER_WIN = 16;
  localparam int AVG_WINS = 10;
  localparam int SAMPLE_CYC_DEF = REFRESH_MS * 1000000 / CLK_PERIOD_NS / SAMPLES_PER_WIN;
  // disconnect timing and minimum current
  localparam int DIS_TIME_MS_DEF = 350;
  localparam int DIS_MIN_UA = 7500;
  localparam int CUR_LSB_UA_DEF = 100;
  // ahb byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_PRIO = 8'h04;
  localparam logic [7:0] OFS_DCDIS = 8'h08;
  localparam logic [7:0] OFS_ACDIS = 8'h0c;
  localparam logic [7:0] OFS_DETEN = 8'h10;
  localparam logic [7:0] OFS_PWRON = 8'h14;
  localparam logic [7:0] OFS_TCUTEV = 8'h18;
  localparam logic [7:0] OFS_POLEV = 8'h1c;
  localparam logic [7:0] OFS_DISEV = 8'h20;
  localparam logic [7:0] OFS_INTMASK = 8'h24;
  localparam logic [7:0] OFS_VEE = 8'h28;
  localparam logic [7:0] OFS_ADDR = 8'h2c;
  localparam logic [7:0] OFS_CHIPRST = 8'h30;
  localparam logic [1:0] BANK_THR = 2'h1;
  localparam logic [1:0] BANK_CUR = 2'h2;
  localparam logic [1:0] BANK_VOLT = 2'h3;
  // control register fields
  localparam int CTRL_AVG = 0;
  localparam int CTRL_POLICE = 1;
  localparam int CTRL_SHEDPOL = 2;
  // reset values
  localparam logic [2:0] CTRL_RST = 3'h0;
  localparam logic [11:0] PRIO_RST = 12'h000;
  localparam logic [11:0] DCDIS_RST = 12'hfff;
  localparam logic [11:0] ACDIS_RST = 12'h000;
  localparam logic [11:0] DETEN_RST = 12'hfff;
  localparam logic [2:0] INTMASK_RST = 3'h0;
  localparam logic [11:0] THR_RST = 12'hfff;
  // two-wire bus addresses and commands
  localparam logic [6:0] BCAST_ADDR = 7'h30;
  localparam logic [6:0] ARA_ADDR = 7'h0c;
  localparam logic [7:0] CMD_STAT = 8'h00;
  localparam logic [7:0] CMD_EVT = 8'h01;
  localparam logic [7:0] CMD_DIS = 8'h02;
  localparam logic [7:0] CMD_PRIO = 8'h10;
  localparam logic [7:0] CMD_DETEN = 8'h11;
  localparam logic [7:0] CMD_SHEDPOL = 8'h1a;
  localparam logic [7:0] CMD_CHIPRST = 8'h1b;

  typedef struct packed {
    logic [11:0] volt;
    logic [11:0] cur;
  } psv_meas_s;

  typedef struct packed {
    logic high;
    logic [3:0] low;
  } psv_strap_s;

  typedef enum logic [2:0] {I2C_IDLE, I2C_RX, I2C_ACK, I2C_TX, I2C_RACK} psv_i2c_e;
endpackage

/* rtl/psv_supervisor.sv */
// port supervision, load shedding, ahb registers and two-wire slave front end
// assumes converter samples and timer expiries arrive on mclk; pins are asynchronous
//
// Notes on behaviour
// - readbacks read zero while port is off
// - fast mode refreshes current every 100ms
// - average mode reports one-second moving average
// - police trip powers off, sets both events
// - timer expiry sets only the timer event
// - disconnect timer advances below 7.5mA
// - disconnect expiry powers off, sets flag
// - current above minimum clears disconnect timer
// - cleared enables skip disconnect checking
// - ac enable bits request dc checking
// - shedding turns low-priority ports off fast
// - shed ports lose detection enable
// - shed polarity selectable, default active low
// - supply voltage readable as 12 bits
// - slave only; host masters every transfer
// - primary address from straps, bits 5:4=10
// - broadcast address accepts writes
// - alert response address while interrupt active
// - three quads at consecutive addresses
// - addresses outside x10xxxx, except broadcast and alert response, not acknowledged
// - quad writes local; polarity, reset global
// - maskable events drive interrupt line
//
// Local design decisions: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ps
module psv_supervisor
  import psv_pkg::*;
#(
  parameter int SAMPLE_CYC = SAMPLE_CYC_DEF, // cycles between current samples
  parameter int DIS_TIME_MS = DIS_TIME_MS_DEF, // disconnect_timer length
  parameter int CUR_LSB_UA = CUR_LSB_UA_DEF // weight of one current code
) (
  input wire logic mclk, // system clock
  input wire logic nrst, // asynchronous reset
  input wire logic hsel, // ahb select
  input wire logic [31:0] haddr, // ahb address
  input wire logic [1:0] htrans, // ahb transfer type
  input wire logic hwrite, // ahb write
  input wire logic [2:0] hsize, // ahb size, word only
  input wire logic [31:0] hwdata, // ahb write data
  input wire logic hready, // ahb bus ready
  output logic [31:0] hrdata, // ahb read data
  output logic hreadyout, // ahb slave ready
  output logic hresp, // ahb response
  input wire psv_meas_s [NPORT-1:0] meas, // per port converter codes
  input wire logic [11:0] veeCode, // supply converter code
  input wire logic [NPORT-1:0] tcutExpire, // overcurrent_fault_timer expiry pulses
  input wire logic loadShedInput, // shedding pin
  input wire psv_strap_s addrStrap, // address strap pins
  input wire logic sclIn, // bus clock pin
  input wire logic sdaIn, // bus data pin
  output logic sdaOut, // bus data drive level
  output logic sdaOe, // bus data pulled low
  output logic intOut, // interrupt drive level
  output logic intOe, // interrupt pulled low
  output logic [NPORT-1:0] portPowerOn // port power enables
);
  localparam int DIS_TICKS = DIS_TIME_MS * SAMPLES_PER_WIN / REFRESH_MS;
  localparam logic [11:0] DIS_MIN_CODE = 12'(DIS_MIN_UA / CUR_LSB_UA);

  // one-second average from the ten window sum
  function automatic logic [11:0] div10(input logic [15:0] s);
    logic [31:0] p;
    p = 32'(s) * 32'd6554;
    return p[27:16];
  endfunction

  // pin synchronisers: shed, scl, sda, straps
  logic [7:0] sync1_ff;
  logic [7:0] sync2_ff;
  logic sclD_ff;
  logic sdaD_ff;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      sync1_ff <= 8'he0; // shed, scl and sda start at their idle high level
      sync2_ff <= 8'he0;
      sclD_ff <= 1'b1;
      sdaD_ff <= 1'b1;
    end else begin
      sync1_ff <= {loadShedInput, sclIn, sdaIn, addrStrap};
      sync2_ff <= sync1_ff;
      sclD_ff <= sync2_ff[6];
      sdaD_ff <= sync2_ff[5];
    end
  end
  logic shedS;
  logic sclS;
  logic sdaS;
  assign shedS = sync2_ff[7];
  assign sclS = sync2_ff[6];
  assign sdaS = sync2_ff[5];

  // straps caught once after the synchronisers settle
  logic [1:0] strapWait_ff;
  logic [6:0] primAddr_ff;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      strapWait_ff <= 2'd0;
      primAddr_ff <= 7'h20;
    end else if (strapWait_ff != 2'd3) begin
      strapWait_ff <= strapWait_ff + 2'd1;
      primAddr_ff <= {sync2_ff[4], 2'b10, sync2_ff[3:0]};
    end
  end

  // sample tick divider and window counters
  logic [31:0] divCnt_ff;
  logic tick_ff;
  logic [3:0] subCnt_ff;
  logic [3:0] slot_ff;
  logic avgFresh_ff;
  logic winEnd;
  assign winEnd = tick_ff && subCnt_ff == 4'(SAMPLES_PER_WIN - 1);
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      divCnt_ff <= '0;
      tick_ff <= 1'b0;
      subCnt_ff <= '0;
      slot_ff <= '0;
      avgFresh_ff <= 1'b0;
    end else begin
      tick_ff <= divCnt_ff == 32'(SAMPLE_CYC - 1);
      divCnt_ff <= (divCnt_ff == 32'(SAMPLE_CYC - 1)) ? '0 : divCnt_ff + 32'd1;
      avgFresh_ff <= winEnd;
      if (tick_ff) begin
        subCnt_ff <= subCnt_ff + 4'd1;
      end
      if (winEnd) begin
        slot_ff <= (slot_ff == 4'(AVG_WINS - 1)) ? 4'd0 : slot_ff + 4'd1;
      end
    end
  end

  // window accumulation, 100ms value and one-second ring
  logic [15:0] acc_ff [NPORT];
  logic [11:0] last_ff [NPORT];
  logic [15:0] sum1s_ff [NPORT];
  logic [11:0] ring_ff [NPORT][AVG_WINS];
  logic [11:0] newAvg [NPORT];
  always_comb begin
    for (int i = 0; i < NPORT; i++) begin
      newAvg[i] = 12'((acc_ff[i] + 16'(meas[i].cur)) >> 4);
    end
  end
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < NPORT; i++) begin
        acc_ff[i] <= '0;
        last_ff[i] <= '0;
        sum1s_ff[i] <= '0;
        for (int k = 0; k < AVG_WINS; k++) begin
          ring_ff[i][k] <= '0;
        end
      end
    end else begin
      for (int i = 0; i < NPORT; i++) begin
        if (tick_ff) begin
          acc_ff[i] <= winEnd ? 16'd0 : acc_ff[i] + 16'(meas[i].cur);
        end
        if (winEnd) begin
          last_ff[i] <= newAvg[i];
          ring_ff[i][slot_ff] <= newAvg[i];
          sum1s_ff[i] <= sum1s_ff[i] + 16'(newAvg[i]) - 16'(ring_ff[i][slot_ff]);
        end
      end
    end
  end

  // ahb address phase capture, zero wait states
  logic aWr_ff;
  logic [7:0] aAddr_ff;
  logic [31:0] hrdata_ff;
  logic [31:0] rdMux;
  logic aPhase;
  assign aPhase = hsel && htrans[1] && hready;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      aWr_ff <= 1'b0;
      aAddr_ff <= '0;
      hrdata_ff <= '0;
    end else begin
      aWr_ff <= aPhase && hwrite;
      aAddr_ff <= haddr[7:0];
      if (aPhase && !hwrite) begin
        hrdata_ff <= rdMux;
      end
    end
  end
  assign hrdata = hrdata_ff;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // configuration registers
  logic [2:0] ctrl_ff;
  logic [11:0] prio_ff;
  logic [11:0] dcDis_ff;
  logic [11:0] acDis_ff;
  logic [2:0] intMask_ff;
  logic [11:0] thr_ff [NPORT];
  logic i2cWr_ff;
  logic [7:0] i2cCmd_ff;
  logic [7:0] i2cData_ff;
  logic [2:0] i2cQuads_ff;
  logic ahbBankWr;
  assign ahbBankWr = aWr_ff && aAddr_ff[7:6] == BANK_THR && aAddr_ff[5:2] < 4'(NPORT);
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ctrl_ff <= CTRL_RST;
      prio_ff <= PRIO_RST;
      dcDis_ff <= DCDIS_RST;
      acDis_ff <= ACDIS_RST;
      intMask_ff <= INTMASK_RST;
      for (int i = 0; i < NPORT; i++) begin
        thr_ff[i] <= THR_RST;
      end
    end else begin
      if (aWr_ff) begin
        unique case (aAddr_ff)
          OFS_CTRL: ctrl_ff <= hwdata[2:0];
          OFS_PRIO: prio_ff <= hwdata[11:0];
          OFS_DCDIS: dcDis_ff <= hwdata[11:0];
          OFS_ACDIS: acDis_ff <= hwdata[11:0];
          OFS_INTMASK: intMask_ff <= hwdata[2:0];
          default: ;
        endcase
      end
      if (ahbBankWr) begin
        thr_ff[aAddr_ff[5:2]] <= hwdata[11:0];
      end
      if (i2cWr_ff && i2cCmd_ff == CMD_SHEDPOL) begin
        ctrl_ff[CTRL_SHEDPOL] <= i2cData_ff[0];
      end
      for (int q = 0; q < NQUAD; q++) begin
        if (i2cWr_ff && i2cCmd_ff == CMD_PRIO && i2cQuads_ff[q]) begin
          prio_ff[4*q +: 4] <= i2cData_ff[3:0];
        end
      end
    end
  end

  // per port trip conditions
  logic shedAct;
  logic chipRst;
  logic [NPORT-1:0] portOn_ff;
  logic [NPORT-1:0] detEn_ff;
  logic [NPORT-1:0] tcutEv_ff;
  logic [NPORT-1:0] polEv_ff;
  logic [NPORT-1:0] disEv_ff;
  logic [7:0] disCnt_ff [NPORT];
  logic [NPORT-1:0] disRun;
  logic [NPORT-1:0] disExp;
  logic [NPORT-1:0] polTrip;
  logic [NPORT-1:0] shedOff;
  assign shedAct = shedS == ctrl_ff[CTRL_SHEDPOL];
  assign chipRst = (aWr_ff && aAddr_ff == OFS_CHIPRST && hwdata[0]) || (i2cWr_ff && i2cCmd_ff == CMD_CHIPRST);
  always_comb begin
    for (int i = 0; i < NPORT; i++) begin
      disRun[i] = portOn_ff[i] && (dcDis_ff[i] || acDis_ff[i]) && meas[i].cur < DIS_MIN_CODE;
      disExp[i] = disRun[i] && tick_ff && disCnt_ff[i] == 8'(DIS_TICKS - 1);
      polTrip[i] = ctrl_ff[CTRL_POLICE] && portOn_ff[i] && avgFresh_ff && div10(sum1s_ff[i]) > thr_ff[i];
      shedOff[i] = shedAct && !prio_ff[i] && portOn_ff[i];
    end
  end

  // disconnect timers
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < NPORT; i++) begin
        disCnt_ff[i] <= '0;
      end
    end else begin
      for (int i = 0; i < NPORT; i++) begin
        if (!disRun[i] || disExp[i]) begin
          disCnt_ff[i] <= '0;
        end else if (tick_ff) begin
          disCnt_ff[i] <= disCnt_ff[i] + 8'd1;
        end
      end
    end
  end

  // a power-on write turns on only ports whose detection is enabled
  logic [NPORT-1:0] pwrReq;
  assign pwrReq = (aWr_ff && aAddr_ff == OFS_PWRON) ? (hwdata[11:0] & detEn_ff) : '0;

  // port power and detection enables
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      portOn_ff <= '0;
      detEn_ff <= DETEN_RST;
    end else begin
      if (aWr_ff && aAddr_ff == OFS_DETEN) begin
        detEn_ff <= hwdata[11:0];
      end
      for (int q = 0; q < NQUAD; q++) begin
        if (i2cWr_ff && i2cCmd_ff == CMD_DETEN && i2cQuads_ff[q]) begin
          detEn_ff[4*q +: 4] <= i2cData_ff[3:0];
        end
      end
      if (|shedOff) begin
        detEn_ff <= detEn_ff & ~shedOff;
      end
      portOn_ff <= (portOn_ff | pwrReq) & ~(shedOff | disExp | polTrip | tcutExpire);
      if (chipRst) begin
        portOn_ff <= '0;
      end
    end
  end
  assign portPowerOn = portOn_ff;

  // event flags, write one to clear, a new event wins
  logic [NPORT-1:0] clrT;
  logic [NPORT-1:0] clrP;
  logic [NPORT-1:0] clrD;
  assign clrT = (aWr_ff && aAddr_ff == OFS_TCUTEV) ? hwdata[11:0] : '0;
  assign clrP = (aWr_ff && aAddr_ff == OFS_POLEV) ? hwdata[11:0] : '0;
  assign clrD = (aWr_ff && aAddr_ff == OFS_DISEV) ? hwdata[11:0] : '0;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      tcutEv_ff <= '0;
      polEv_ff <= '0;
      disEv_ff <= '0;
    end else if (chipRst) begin
      tcutEv_ff <= '0;
      polEv_ff <= '0;
      disEv_ff <= '0;
    end else begin
      tcutEv_ff <= (tcutEv_ff & ~clrT) | (portOn_ff & (tcutExpire | polTrip));
      polEv_ff <= (polEv_ff & ~clrP) | polTrip;
      disEv_ff <= (disEv_ff & ~clrD) | disExp;
    end
  end

  // interrupt line and constant low drive level of both open-drain pins
  logic intAct;
  logic intOe_ff;
  logic odLow_ff;
  assign intAct = (intMask_ff[0] && |tcutEv_ff) || (intMask_ff[1] && |polEv_ff) || (intMask_ff[2] && |disEv_ff);
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      intOe_ff <= 1'b0;
      odLow_ff <= 1'b0;
    end else begin
      intOe_ff <= intAct;
    end
  end
  assign intOe = intOe_ff;
  assign intOut = odLow_ff;
  assign sdaOut = odLow_ff;

  // ahb read data selection
  always_comb begin
    logic [3:0] idx;
    idx = haddr[5:2];
    rdMux = '0;
    unique case (haddr[7:0])
      OFS_CTRL: rdMux[2:0] = ctrl_ff;
      OFS_PRIO: rdMux[11:0] = prio_ff;
      OFS_DCDIS: rdMux[11:0] = dcDis_ff;
      OFS_ACDIS: rdMux[11:0] = acDis_ff;
      OFS_DETEN: rdMux[11:0] = detEn_ff;
      OFS_PWRON: rdMux[11:0] = portOn_ff;
      OFS_TCUTEV: rdMux[11:0] = tcutEv_ff;
      OFS_POLEV: rdMux[11:0] = polEv_ff;
      OFS_DISEV: rdMux[11:0] = disEv_ff;
      OFS_INTMASK: rdMux[2:0] = intMask_ff;
      OFS_VEE: rdMux[11:0] = veeCode;
      OFS_ADDR: rdMux[6:0] = primAddr_ff;
      default: begin
        if (idx < 4'(NPORT) && portOn_ff[idx]) begin
          unique case (haddr[7:6])
            BANK_CUR: rdMux[11:0] = ctrl_ff[CTRL_AVG] ? div10(sum1s_ff[idx]) : last_ff[idx];
            BANK_VOLT: rdMux[11:0] = meas[idx].volt;
            default: ;
          endcase
        end
        if (idx < 4'(NPORT) && haddr[7:6] == BANK_THR) begin
          rdMux[11:0] = thr_ff[idx];
        end
      end
    endcase
  end

  // two-wire slave: address match and transmit byte
  psv_i2c_e st_ff;
  logic [7:0] sh_ff;
  logic [7:0] txSh_ff;
  logic [3:0] bitCnt_ff;
  logic isAddr_ff;
  logic haveCmd_ff;
  logic rw_ff;
  logic ara_ff;
  logic [1:0] quad_ff;
  logic sdaOe_ff;
  logic [6:0] rxA;
  logic [6:0] rel;
  logic hitQuad;
  logic hitBcast;
  logic hitAra;
  logic [7:0] txByte;
  logic [3:0] nib;
  assign rxA = sh_ff[7:1];
  assign rel = rxA - primAddr_ff;
  assign hitQuad = rxA[5:4] == 2'b10 && rel < 7'(NQUAD);
  assign hitBcast = rxA == BCAST_ADDR && !sh_ff[0];
  assign hitAra = rxA == ARA_ADDR && sh_ff[0] && intOe_ff;
  always_comb begin
    txByte = 8'h00;
    nib = 4'(quad_ff) << 2;
    unique case (i2cCmd_ff)
      CMD_STAT: txByte = {prio_ff[nib +: 4], portOn_ff[nib +: 4]};
      CMD_EVT: txByte = {polEv_ff[nib +: 4], tcutEv_ff[nib +: 4]};
      CMD_DIS: txByte = {detEn_ff[nib +: 4], disEv_ff[nib +: 4]};
      default: ;
    endcase
    if (ara_ff) begin
      txByte = {primAddr_ff, 1'b0};
    end
  end

  // two-wire slave state machine, never drives the bus clock
  logic sclRise;
  logic sclFall;
  logic startC;
  logic stopC;
  assign sclRise = sclS && !sclD_ff;
  assign sclFall = !sclS && sclD_ff;
  assign startC = sclS && sclD_ff && sdaD_ff && !sdaS;
  assign stopC = sclS && sclD_ff && !sdaD_ff && sdaS;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      st_ff <= I2C_IDLE;
      sh_ff <= '0;
      txSh_ff <= '0;
      bitCnt_ff <= '0;
      isAddr_ff <= 1'b0;
      haveCmd_ff <= 1'b0;
      rw_ff <= 1'b0;
      ara_ff <= 1'b0;
      quad_ff <= '0;
      sdaOe_ff <= 1'b0;
      i2cWr_ff <= 1'b0;
      i2cCmd_ff <= '0;
      i2cData_ff <= '0;
      i2cQuads_ff <= '0;
    end else begin
      i2cWr_ff <= 1'b0;
      if (startC) begin
        st_ff <= I2C_RX;
        bitCnt_ff <= '0;
        isAddr_ff <= 1'b1;
        haveCmd_ff <= 1'b0;
        sdaOe_ff <= 1'b0;
      end else if (stopC) begin
        st_ff <= I2C_IDLE;
        sdaOe_ff <= 1'b0;
      end else begin
        unique case (st_ff)
          I2C_IDLE: ;
          I2C_RX: begin
            if (sclRise) begin
              sh_ff <= {sh_ff[6:0], sdaS};
              bitCnt_ff <= bitCnt_ff + 4'd1;
            end else if (sclFall && bitCnt_ff == 4'd8) begin
              bitCnt_ff <= '0;
              isAddr_ff <= 1'b0;
              if (isAddr_ff) begin
                rw_ff <= sh_ff[0];
                ara_ff <= hitAra;
                quad_ff <= rel[1:0];
                i2cQuads_ff <= hitBcast ? 3'b111 : 3'b001 << rel[1:0];
                st_ff <= (hitQuad || hitBcast || hitAra) ? I2C_ACK : I2C_IDLE;
                sdaOe_ff <= hitQuad || hitBcast || hitAra;
              end else begin
                haveCmd_ff <= 1'b1;
                if (!haveCmd_ff) begin
                  i2cCmd_ff <= sh_ff;
                end else begin
                  i2cWr_ff <= 1'b1;
                  i2cData_ff <= sh_ff;
                end
                st_ff <= I2C_ACK;
                sdaOe_ff <= 1'b1;
              end
            end
          end
          I2C_ACK: begin
            if (sclFall) begin
              st_ff <= rw_ff ? I2C_TX : I2C_RX;
              txSh_ff <= txByte;
              sdaOe_ff <= rw_ff && !txByte[7];
              bitCnt_ff <= rw_ff ? 4'd1 : 4'd0;
            end
          end
          I2C_TX: begin
            if (sclRise && !sdaOe_ff && !sdaS) begin
              st_ff <= I2C_IDLE;
            end else if (sclFall && bitCnt_ff == 4'd8) begin
              st_ff <= I2C_RACK;
              sdaOe_ff <= 1'b0;
            end else if (sclFall) begin
              txSh_ff <= {txSh_ff[6:0], 1'b0};
              sdaOe_ff <= !txSh_ff[6];
              bitCnt_ff <= bitCnt_ff + 4'd1;
            end
          end
          I2C_RACK: begin
            if (sclRise) begin
              st_ff <= sdaS ? I2C_IDLE : I2C_ACK;
            end
          end
        endcase
      end
    end
  end
  assign sdaOe = sdaOe_ff;
endmodule // psv_supervisor

/* sim/psv_supervisor_checker.sv */
// port assertions of the supervisor
// bound into every psv_supervisor instance
`timescale 1ns/1ps
module psv_supervisor_checker
  import psv_pkg::*;
(
  input wire logic mclk, // clock
  input wire logic nrst, // reset
  input wire logic hsel, // select
  input wire logic [1:0] htrans, // transfer
  input wire logic hwrite, // write
  input wire logic hready, // ready in
  input wire logic [31:0] hwdata, // wdata
  input wire logic [31:0] hrdata, // rdata
  input wire logic hreadyout, // ready out
  input wire logic hresp, // response
  input wire logic [NPORT-1:0] tcutExpire, // expiry
  input wire logic sdaOut, // sda level
  input wire logic sdaOe, // sda enable
  input wire logic intOut, // int level
  input wire logic [NPORT-1:0] portPowerOn // power
);
  // one domain, one reset
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);
  // bus answers, pin levels and power causes
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not okay");
  a_quiet_start: assert property ($rose(nrst) |-> !sdaOe [*8])
    else $error("sda pulled after reset");
  a_reset_off: assert property ($rose(nrst) |-> portPowerOn == '0)
    else $error("port on after reset");
  a_overcurrent_fault_timer_off: assert property (tcutExpire[1] |-> ##[1:2] !portPowerOn[1])
    else $error("port kept on after expiry");
  a_pwr_cause: assert property ($rose(portPowerOn[0]) |-> $past(hwdata[0]))
    else $error("port on without request");
  a_sda_level: assert property (!sdaOut)
    else $error("sda driven high");
  a_int_level: assert property (!intOut)
    else $error("int driven high");
  a_rdata_hold: assert property ($changed(hrdata) |-> $past(hsel && htrans[1] && !hwrite && hready))
    else $error("read data moved");
endmodule // psv_supervisor_checker
bind psv_supervisor psv_supervisor_checker psv_supervisor_checker_i (.mclk, .nrst, .hsel, .htrans,
  .hwrite, .hready, .hwdata, .hrdata, .hreadyout, .hresp, .tcutExpire, .sdaOut, .sdaOe, .intOut, .portPowerOn);

/* sim/psv_host_master.sv */
// host model: two-wire bus master
// sda is open drain, pulled up in the bench
`timescale 1ns/1ps
module psv_host_master (
  input wire logic mclk, // pacing clock
  input wire logic sdaLine, // sda level
  output logic scl, // bus clock
  output logic sdaLow // pulls sda low
);
  // idle bus: both lines high
  initial begin
    scl = 1'b1;
    sdaLow = 1'b0;
  end
  // quarter of the 80 ns bus clock
  task automatic q();
    repeat (4) @(posedge mclk);
  endtask
  // one bit; s is sda late in the high phase
  task automatic bit1(input logic v, output logic s);
    q();
    sdaLow <= !v;
    q();
    scl <= 1'b1;
    q();
    q();
    s = sdaLine;
    scl <= 1'b0;
  endtask
  // start, three bytes, stop; ok when all acknowledged
  task automatic write3(input logic [6:0] a, input logic [7:0] c, input logic [7:0] d, output logic ok);
    logic [26:0] b;
    logic s;
    b = {a, 1'b0, 1'b1, c, 1'b1, d, 1'b1};
    ok = 1'b1;
    sdaLow <= 1'b1;
    q();
    scl <= 1'b0;
    for (int i = 26; i >= 0; i--) begin
      bit1(b[i], s);
      if (i % 9 == 0) ok = ok & !s;
    end
    q();
    sdaLow <= 1'b1;
    q();
    scl <= 1'b1;
    q();
    sdaLow <= 1'b0;
    q();
  endtask
endmodule // psv_host_master

/* sim/psv_supervisor_tb.sv */
// self-checking bench for the port supervisor
// ahb and pins driven here; a host model works the two-wire bus
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin miscompares++; $display("BAD %0t got %h exp %h", $time, g, e); end end
module psv_supervisor_tb;
  import psv_pkg::*;
  logic mclk, nrst, hsel, hwrite, hreadyout, hresp, loadShedInput, scl, sdaLow, sdaOut, sdaOe, intOut, intOe;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata;
  logic [NPORT-1:0] tcutExpire, portPowerOn;
  psv_meas_s [NPORT-1:0] meas;
  psv_strap_s addrStrap;
  int miscompares = 0;
  int samples_checked = 0;
  // pulled-up open drain data line
  wire logic sdaLine = (sdaOe ? sdaOut : 1'b1) & !sdaLow;
  psv_supervisor #(.SAMPLE_CYC(8)) psv_supervisor_i (.mclk, .nrst, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .meas, .veeCode(12'h5a3),
    .tcutExpire, .loadShedInput, .addrStrap, .sclIn(scl), .sdaIn(sdaLine), .sdaOut, .sdaOe, .intOut,
    .intOe, .portPowerOn);
  psv_host_master psv_host_master_i (.mclk, .sdaLine, .scl, .sdaLow);
  // 200 MHz clock
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  task automatic final_report();
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // single word transfer; read data taken at the end of the data phase
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    for (int p = 0; p < 2; p++) begin
      do begin
        @(posedge mclk);
        n++;
        if (n > 50) begin
          miscompares++;
          final_report();
        end
      end while (hreadyout !== 1'b1);
      if (p == 0) begin
        htrans <= 2'h0;
        hwdata <= d;
      end
    end
    r = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    ahb(1'b1, a, d, r);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    ahb(1'b0, a, 32'h0, r);
    `CHK(r, e)
  endtask
  // wait a bounded time for the power enables
  task automatic pwr(input logic [11:0] e, input int lim);
    for (int n = 0; n < lim && portPowerOn !== e; n++) @(posedge mclk);
    `CHK(portPowerOn, e)
    if (portPowerOn !== e) final_report();
  endtask
  task automatic t_reset();
    rd(OFS_CTRL, 32'h0);
    rd(OFS_DCDIS, 32'hfff);
    rd(OFS_VEE, 32'h5a3);
    rd(OFS_ADDR, 32'h22);
    rd(8'h3c, 32'h0);
    pwr(12'h000, 1);
    $display("reset test done");
  endtask
  task automatic t_power();
    wr(OFS_PWRON, 32'hfff);
    pwr(12'hfff, 4);
    rd(8'hc4, 32'hc8);
    tcutExpire <= 12'h002;
    @(posedge mclk);
    tcutExpire <= 12'h000;
    pwr(12'hffd, 4);
    rd(OFS_TCUTEV, 32'h2);
    rd(OFS_POLEV, 32'h0);
    rd(8'hc4, 32'h0);
    rd(8'h84, 32'h0);
    $display("power test done");
  endtask
  task automatic t_shed();
    wr(OFS_PRIO, 32'h00f);
    loadShedInput <= 1'b0;
    pwr(12'h00d, 1300);
    rd(OFS_DETEN, 32'h00f);
    loadShedInput <= 1'b1;
    wr(OFS_PWRON, 32'hfff);
    pwr(12'h00f, 4);
    wr(OFS_PRIO, 32'h0);
    wr(OFS_CTRL, 32'h4);
    pwr(12'h000, 1300);
    wr(OFS_CTRL, 32'h0);
    $display("shed test done");
  endtask
  task automatic t_disc();
    wr(OFS_DETEN, 32'hfff);
    wr(OFS_DCDIS, 32'h001);
    wr(OFS_ACDIS, 32'h002);
    meas <= {NPORT{24'h0c800a}};
    wr(OFS_PWRON, 32'h007);
    pwr(12'h007, 4);
    repeat (300) @(posedge mclk);
    meas <= {NPORT{24'h0c8064}};
    repeat (16) @(posedge mclk);
    meas <= {NPORT{24'h0c800a}};
    repeat (400) @(posedge mclk);
    `CHK(portPowerOn, 12'h007)
    pwr(12'h004, 150);
    rd(OFS_DISEV, 32'h3);
    $display("disconnect test done");
  endtask
  // readback modes, then a police trip on port 2 with its interrupt
  task automatic t_police();
    meas <= {NPORT{24'h0c8064}};
    repeat (1500) @(posedge mclk);
    rd(8'h88, 32'h64);
    wr(OFS_CTRL, 32'h1);
    rd(8'h88, 32'h64);
    wr(OFS_INTMASK, 32'h2);
    wr(8'h48, 32'h50);
    wr(OFS_CTRL, 32'h2);
    pwr(12'h000, 300);
    rd(OFS_POLEV, 32'h4);
    rd(OFS_TCUTEV, 32'h6);
    `CHK(intOe, 1'b1)
    $display("police test done");
  endtask
  task automatic t_bus();
    logic ok;
    psv_host_master_i.write3(7'h23, CMD_PRIO, 8'h05, ok);
    `CHK(ok, 1'b1)
    rd(OFS_PRIO, 32'h050);
    psv_host_master_i.write3(BCAST_ADDR, CMD_PRIO, 8'h03, ok);
    `CHK(ok, 1'b1)
    rd(OFS_PRIO, 32'h333);
    psv_host_master_i.write3(7'h12, CMD_PRIO, 8'h0f, ok);
    `CHK(ok, 1'b0)
    rd(OFS_PRIO, 32'h333);
    $display("bus test done");
  endtask
  // reset, then the scenarios in turn
  initial begin
    nrst = 1'b0;
    hsel = 1'b0;
    htrans = 2'h0;
    hwrite = 1'b0;
    haddr = 32'h0;
    hwdata = 32'h0;
    loadShedInput = 1'b1;
    tcutExpire = '0;
    addrStrap = '{1'b0, 4'h2};
    meas = {NPORT{24'h0c8064}};
    repeat (2) @(posedge mclk);
    nrst <= 1'b1;
    repeat (12) @(posedge mclk);
    t_reset();
    t_power();
    t_shed();
    t_disc();
    t_police();
    t_bus();
    final_report();
  end
endmodule // psv_supervisor_tb
